// file: hw/output_fault_substitution.sv
/*
  Output fault substitution and bus timing supervision of a fieldbus master gateway.
  Assumes synchronous inputs, a 50 MHz clock, and a bit tick pulse at the bus bit rate.
*/
module output_fault_substitution
  import ofs_pkg::*;
#(
  parameter int NUM_MOD          = 4,
  parameter int MOD_BYTES        = 8,
  parameter int NUM_GROUPS       = 4,
  parameter int MS_TICK_CYCLES_P = ofs_pkg::MS_TICK_CYCLES,
  parameter int SLOT_UNIT_P      = ofs_pkg::SLOT_UNIT_CYCLES
)
(
  // Clock and reset.
  input  wire logic                                 clk,
  input  wire logic                                 rst_n,
  input  wire logic                                 syncClear,
  // Module memory blocks.
  input  wire logic [NUM_MOD-1:0]                   blockAccess,
  input  wire logic [NUM_MOD-1:0][15:0]             timeoutMs,
  input  wire logic [NUM_MOD-1:0][MOD_BYTES-1:0][7:0] blockData,
  input  wire logic [NUM_MOD-1:0][MOD_BYTES-1:0][7:0] faultPattern,
  input  wire logic [NUM_MOD-1:0][MOD_BYTES-1:0][7:0] slaveInData,
  input  wire logic [NUM_MOD-1:0][1:0]              moduleGroup,
  // Group commands.
  input  ofs_pkg::groupCmd_t [NUM_GROUPS-1:0]       groupCmd,
  // Module data toward the bus and the host.
  output logic      [NUM_MOD-1:0][MOD_BYTES-1:0][7:0] busOutData,
  output logic      [NUM_MOD-1:0][MOD_BYTES-1:0][7:0] hostInData,
  output logic      [NUM_MOD-1:0]                   faultActive,
  // Bus configuration.
  input  ofs_pkg::busCfg_t                          busCfg,
  input  wire logic                                 bitTick,
  // Transaction control.
  input  wire logic                                 reqTrigger,
  input  wire logic                                 respValid,
  output logic                                      txStart,
  output logic                                      respOk,
  output logic                                      respEarly,
  output logic                                      respLate,
  output logic                                      noAnswer,
  output logic      [3:0]                           retryCount,
  output logic                                      busBusy,
  // Token rotation and gap maintenance.
  input  wire logic                                 tokenRx,
  output logic                                      rotationOverrun,
  output logic                                      gapDue,
  output logic      [6:0]                           gapAddr,
  // Parameterisation.
  input  wire logic                                 prmStage,
  output logic      [15:0]                          prmWatchdogMs,
  output logic                                      cfgError
);

  typedef struct packed {
    logic [31:0]                      msCnt;
    logic                             msTick;
    busState_t                        busSt;
    logic [31:0]                      unitCnt;
    logic [15:0]                      slotCnt;
    logic [7:0]                       setupCnt;
    logic [15:0]                      respBits;
    logic [3:0]                       retryCnt;
    logic                             txStart;
    logic                             respOk;
    logic                             respEarly;
    logic                             respLate;
    logic                             noAnswer;
    logic [23:0]                      rotCnt;
    logic                             rotOverrun;
    logic [7:0]                       roundCnt;
    logic                             gapDue;
    logic [6:0]                       gapAddr;
    logic [15:0]                      prmWd;
    logic [NUM_MOD-1:0][MOD_BYTES-1:0][7:0] subData;
  } topState_t;

  topState_t          st_q;
  topState_t          st_d;
  logic [NUM_MOD-1:0] faultFlag;

  ////////////////////////////////////////////////////////////////////////////////
  // Per-module supervision and group latching.

  for (genvar m = 0; m < NUM_MOD; m++)
  begin : gMod
    groupCmd_t modCmd;

    assign modCmd = groupCmd[moduleGroup[m]];

    module_supervisor uSup (
      .clk         (clk),
      .rst_n       (rst_n),
      .syncClear   (syncClear),
      .msTick      (st_q.msTick),
      .access      (blockAccess[m]),
      .timeoutMs   (timeoutMs[m]),
      .faultActive (faultFlag[m])
    );

    group_latch #(
      .W (MOD_BYTES * 8)
    ) uLatch (
      .clk        (clk),
      .rst_n      (rst_n),
      .cmd        (modCmd),
      .outNew     (st_q.subData[m]),
      .inRaw      (slaveInData[m]),
      .outToSlave (busOutData[m]),
      .inToHost   (hostInData[m])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb
  begin
    st_d           = st_q;
    st_d.msTick    = 1'b0;
    st_d.txStart   = 1'b0;
    st_d.respOk    = 1'b0;
    st_d.respEarly = 1'b0;
    st_d.respLate  = 1'b0;
    st_d.noAnswer  = 1'b0;
    st_d.gapDue    = 1'b0;

    // Millisecond tick shared by all supervision timers.
    if (syncClear || st_q.msCnt >= 32'(MS_TICK_CYCLES_P - 1))
    begin
      st_d.msCnt  = '0;
      st_d.msTick = !syncClear;
    end
    else
    begin
      st_d.msCnt = st_q.msCnt + 32'h1;
    end

    // Byte-wise substitution of the fault pattern.
    for (int m = 0; m < NUM_MOD; m++)
    begin
      for (int b = 0; b < MOD_BYTES; b++)
      begin
        st_d.subData[m][b] = faultFlag[m] ? faultPattern[m][b] : blockData[m][b];
      end
    end

    // Request, setup, slot supervision and retry.
    unique case (st_q.busSt)
      BUS_IDLE:
      begin
        if (reqTrigger)
        begin
          st_d.busSt    = BUS_SETUP;
          st_d.setupCnt = '0;
          st_d.retryCnt = '0;
        end
      end
      BUS_SETUP:
      begin
        if (st_q.setupCnt >= busCfg.setupTime)
        begin
          st_d.txStart  = 1'b1;
          st_d.busSt    = BUS_WAIT;
          st_d.unitCnt  = '0;
          st_d.slotCnt  = '0;
          st_d.respBits = '0;
        end
        else if (bitTick)
        begin
          st_d.setupCnt = st_q.setupCnt + 8'h01;
        end
      end
      BUS_WAIT:
      begin
        if (bitTick && st_q.respBits != 16'hffff)
        begin
          st_d.respBits = st_q.respBits + 16'h0001;
        end
        if (st_q.unitCnt >= 32'(SLOT_UNIT_P - 1))
        begin
          st_d.unitCnt = '0;
          st_d.slotCnt = st_q.slotCnt + 16'h0001;
        end
        else
        begin
          st_d.unitCnt = st_q.unitCnt + 32'h1;
        end
        if (respValid)
        begin
          st_d.busSt     = BUS_IDLE;
          st_d.respOk    = 1'b1;
          st_d.respEarly = st_q.respBits < {8'h00, busCfg.minTsdr};
          st_d.respLate  = st_q.respBits > {8'h00, busCfg.maxTsdr};
        end
        else if (st_q.slotCnt >= busCfg.slotTime)
        begin
          if (st_q.retryCnt < busCfg.retryLimit)
          begin
            st_d.retryCnt = st_q.retryCnt + 4'h1;
            st_d.busSt    = BUS_SETUP;
            st_d.setupCnt = '0;
          end
          else
          begin
            st_d.noAnswer = 1'b1;
            st_d.busSt    = BUS_IDLE;
          end
        end
      end
      default:
      begin
        st_d.busSt = BUS_IDLE;
      end
    endcase

    // Token rotation time and gap maintenance.
    if (tokenRx)
    begin
      st_d.rotOverrun = st_q.rotCnt > busCfg.targetRot;
      st_d.rotCnt     = '0;
      if (st_q.roundCnt + 8'h01 >= busCfg.gapFactor)
      begin
        st_d.roundCnt = '0;
        st_d.gapDue   = 1'b1;
        st_d.gapAddr  = (st_q.gapAddr >= busCfg.hsa) ? 7'h00 : st_q.gapAddr + 7'h01;
      end
      else
      begin
        st_d.roundCnt = st_q.roundCnt + 8'h01;
      end
    end
    else if (bitTick && st_q.rotCnt != 24'hffffff)
    begin
      st_d.rotCnt = st_q.rotCnt + 24'h000001;
    end

    // Watchdog time captured for the parameterisation telegram.
    if (prmStage)
    begin
      st_d.prmWd = busCfg.watchdogMs;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign faultActive     = faultFlag;
  assign txStart         = st_q.txStart;
  assign respOk          = st_q.respOk;
  assign respEarly       = st_q.respEarly;
  assign respLate        = st_q.respLate;
  assign noAnswer        = st_q.noAnswer;
  assign retryCount      = st_q.retryCnt;
  assign busBusy         = st_q.busSt != BUS_IDLE;
  assign rotationOverrun = st_q.rotOverrun;
  assign gapDue          = st_q.gapDue;
  assign gapAddr         = st_q.gapAddr;
  assign prmWatchdogMs   = st_q.prmWd;
  assign cfgError        = busCfg.minTsdr < STATION_DLY_MIN || busCfg.maxTsdr < busCfg.minTsdr;

endmodule : output_fault_substitution

// file: hw/ofs_pkg.sv
/*
  Constants, types and helper functions shared by the output fault substitution design.
  Assumes a single 50 MHz clock and an active-low asynchronous reset.
*/
// Functional notes
// - Each output module has its own memory block, watched by its own timer.
// - When a watched block times out, its outputs switch to the fault pattern; in sync mode the code waits for the next sync or unsync command.
// - The fault pattern holds one configurable value per byte, applied byte by byte.
// - Timeouts of 100 to 60000 ms are valid; zero or out of range disables supervision.
// - Any access to the block restarts its timer, even with unchanged data.
// - The master waits at most the slot time, counted in 100 us units.
// - A configured setup time separates the trigger event from the request start.
// - The target rotation time is the expected duration of one token rotation.
// - One gap maintenance cycle runs after each configured number of token rounds.
// - The highest station address bounds the bus addresses in use.
// - An unanswered transaction is retried no more often than the retry limit.
// - The watchdog time goes to each slave during parameterisation.
// - In sync mode the latched outputs are sent; new ones wait for the next command.
// - In freeze mode the frozen inputs are reported; new samples go to a separate buffer.
package ofs_pkg;

  localparam int          CLK_PERIOD_NS   = 20;
  localparam int          MS_TICK_TIME_US = 1000;
  localparam int          MS_TICK_CYCLES  = MS_TICK_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int          SLOT_UNIT_US    = 100;
  localparam int          SLOT_UNIT_CYCLES = SLOT_UNIT_US * 1000 / CLK_PERIOD_NS;

  localparam int          TIMEOUT_W       = 16;
  localparam logic [15:0] TIMEOUT_MIN_MS  = 16'h0064;
  localparam logic [15:0] TIMEOUT_MAX_MS  = 16'hea60;
  localparam logic [7:0]  STATION_DLY_MIN = 8'h0b;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_SETUP,
    BUS_WAIT
  } busState_t;

  typedef struct packed {
    logic [15:0] slotTime;
    logic [7:0]  minTsdr;
    logic [7:0]  maxTsdr;
    logic [7:0]  setupTime;
    logic [23:0] targetRot;
    logic [7:0]  gapFactor;
    logic [6:0]  hsa;
    logic [3:0]  retryLimit;
    logic [15:0] watchdogMs;
  } busCfg_t;

  typedef struct packed {
    logic [15:0] countMs;
    logic        faultActive;
  } supTimer_t;

  typedef struct packed {
    logic sync;
    logic unsync;
    logic freeze;
    logic unfreeze;
  } groupCmd_t;

  function automatic logic timeoutValid(input logic [15:0] t);
    timeoutValid = (t >= TIMEOUT_MIN_MS) && (t <= TIMEOUT_MAX_MS);
  endfunction : timeoutValid

endpackage : ofs_pkg

// file: hw/module_supervisor.sv
/*
  Supervision timer for one output module memory block.
  Assumes msTick is a one-cycle pulse every millisecond from the top level.
*/
module module_supervisor
  import ofs_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        syncClear,
  // Timing and activity.
  input  wire logic        msTick,
  input  wire logic        access,
  input  wire logic [15:0] timeoutMs,
  // Status.
  output logic             faultActive
);

  supTimer_t st_q;
  supTimer_t st_d;

  always_comb
  begin
    st_d = st_q;
    if (syncClear)
    begin
      st_d = '0;
    end
    else if (access)
    begin
      st_d = '0;
    end
    else if (!timeoutValid(timeoutMs))
    begin
      st_d = '0;
    end
    else if (msTick && !st_q.faultActive)
    begin
      st_d.countMs = st_q.countMs + 16'h0001;
      if (st_d.countMs >= timeoutMs)
      begin
        st_d.faultActive = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign faultActive = st_q.faultActive;

endmodule : module_supervisor

// file: hw/group_latch.sv
/*
  Sync and freeze latching of one module's output and input data.
  Assumes group commands are one-cycle pulses.
*/
module group_latch
  import ofs_pkg::*;
#(
  parameter int W = 64
)
(
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Commands.
  input  ofs_pkg::groupCmd_t cmd,
  // Data.
  input  wire logic [W-1:0] outNew,
  input  wire logic [W-1:0] inRaw,
  output logic      [W-1:0] outToSlave,
  output logic      [W-1:0] inToHost
);

  typedef struct packed {
    logic         syncMode;
    logic         freezeMode;
    logic [W-1:0] outHeld;
    logic [W-1:0] outSent;
    logic [W-1:0] inFrozen;
    logic [W-1:0] inShadow;
    logic [W-1:0] inSent;
  } latchState_t;

  latchState_t st_q;
  latchState_t st_d;

  always_comb
  begin
    st_d = st_q;
    if (cmd.sync)
    begin
      st_d.syncMode = 1'b1;
      st_d.outHeld  = outNew;
    end
    else if (cmd.unsync)
    begin
      st_d.syncMode = 1'b0;
    end
    if (cmd.freeze)
    begin
      st_d.freezeMode = 1'b1;
      st_d.inFrozen   = inRaw;
    end
    else if (cmd.unfreeze)
    begin
      st_d.freezeMode = 1'b0;
    end
    st_d.inShadow = inRaw;
    st_d.outSent  = st_d.syncMode ? st_d.outHeld : outNew;
    st_d.inSent   = st_d.freezeMode ? st_d.inFrozen : inRaw;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign outToSlave = st_q.outSent;
  assign inToHost   = st_q.inSent;

endmodule : group_latch

// file: tb/ofs_chk.sv
/*
  Port checker for the output fault substitution top, bound below.
  Assumes one clock and the active-low reset of the top.
*/
module ofs_chk
  import ofs_pkg::*;
#(
  parameter int NUM_MOD = 4
)
(
  // Clock and reset.
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic                    syncClear,
  // Supervision.
  input wire logic [NUM_MOD-1:0]       blockAccess,
  input wire logic [NUM_MOD-1:0][15:0] timeoutMs,
  input wire logic [NUM_MOD-1:0]       faultActive,
  // Transactions and configuration.
  input ofs_pkg::busCfg_t              busCfg,
  input wire logic                    reqTrigger,
  input wire logic                    busBusy,
  input wire logic                    respOk,
  input wire logic                    respEarly,
  input wire logic                    respLate,
  input wire logic                    prmStage,
  input wire logic [15:0]              prmWatchdogMs,
  input wire logic                    cfgError
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////
  sequence zero_s;
    timeoutMs[0] == 16'h0000 ##1 timeoutMs[0] == 16'h0000;
  endsequence
  sequence req_s;
    reqTrigger && !busBusy;
  endsequence

  ////////////////////////////////////////
  access_clears_a: assert property (blockAccess[0] |=> !faultActive[0])
    else $error("fault flag kept after access");
  sync_clear_a: assert property (syncClear |=> faultActive == '0)
    else $error("fault flag kept after clear");
  bad_timeout_a: assert property (zero_s |-> !faultActive[0])
    else $error("fault with supervision off");
  fault_cause_a: assert property ($rose(faultActive[0]) |-> !$past(blockAccess[0]))
    else $error("fault right after access");
  req_busy_a: assert property (req_s |=> busBusy)
    else $error("request not taken");
  resp_idle_a: assert property (respOk |-> !busBusy)
    else $error("busy after response");
  prm_copy_a: assert property (prmStage |=> prmWatchdogMs == $past(busCfg.watchdogMs))
    else $error("watchdog time not copied");
  cfg_err_a: assert property (cfgError == (busCfg.minTsdr < STATION_DLY_MIN || busCfg.maxTsdr < busCfg.minTsdr))
    else $error("config error flag wrong");
  early_flag_a: assert property (respEarly |-> respOk)
    else $error("early flag without response");
  late_flag_a: assert property (respLate |-> respOk)
    else $error("late flag without response");
endmodule : ofs_chk

bind output_fault_substitution ofs_chk #(.NUM_MOD(NUM_MOD)) i_ofs_chk (.clk, .rst_n, .syncClear,
  .blockAccess, .timeoutMs, .faultActive, .busCfg, .reqTrigger, .busBusy, .respOk, .respEarly,
  .respLate, .prmStage, .prmWatchdogMs, .cfgError);

// file: tb/slave_model.sv
/*
  Fieldbus slave model replying a set number of bit times after each request.
  Assumes txStart and bitTick are one-cycle pulses.
*/
module slave_model
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Bus timing.
  input  wire logic       bitTick,
  input  wire logic       txStart,
  input  wire logic [7:0] replyDly,
  // Reply.
  output logic            respValid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_q;
  logic       wait_q;

  // A delay of zero keeps the slave silent.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q     <= 8'h00;
      wait_q    <= 1'b0;
      respValid <= 1'b0;
    end
    else
    begin
      respValid <= 1'b0;
      if (txStart && replyDly != 8'h00)
      begin
        wait_q <= 1'b1;
        cnt_q  <= 8'h00;
      end
      else if (wait_q && bitTick)
      begin
        cnt_q <= cnt_q + 8'h01;
        if (cnt_q + 8'h01 == replyDly)
        begin
          respValid <= 1'b1;
          wait_q    <= 1'b0;
        end
      end
    end
  end
endmodule : slave_model

// file: tb/testbench.sv
/*
  Self-checking bench of the output fault substitution top with a slave model.
  Assumes short tick and slot parameters to keep the run brief.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import ofs_pkg::*;
  typedef struct packed {logic [15:0] tmo; logic flt;} row_t;
  row_t rows [4] = '{'{16'h0064, 1'b1}, '{16'h0000, 1'b0}, '{16'h0063, 1'b0}, '{16'hea61, 1'b0}};
  logic clk = 1'b0, rst_n = 1'b0, syncClear = 1'b0, bitTick = 1'b0;
  logic reqTrigger = 1'b0, tokenRx = 1'b0, prmStage = 1'b0, respValid;
  logic [3:0] blockAccess = 4'h2;
  logic [3:0][15:0] timeoutMs = {16'h0000, 16'h0000, 16'h0064, 16'h0000};
  logic [3:0][7:0][7:0] blockData = {4{64'h0123456789abcdef}}, faultPattern = {4{64'hf1e2d3c4b5a69788}};
  logic [3:0][7:0][7:0] slaveInData = {4{64'h1111}}, busOutData, hostInData;
  logic [3:0][1:0] moduleGroup = 8'h10;
  groupCmd_t [3:0] groupCmd = '0;
  busCfg_t busCfg = '{16'h0064, 8'h0b, 8'h14, 8'h02, 24'h0003e8, 8'h02, 7'h03, 4'h1, 16'h00fa};
  logic [7:0] replyDly = 8'h00;
  logic [3:0] faultActive, retryCount;
  logic txStart, respOk, respEarly, respLate, noAnswer, busBusy, rotationOverrun, gapDue, cfgError;
  logic [6:0] gapAddr;
  logic [15:0] prmWatchdogMs;
  int errCount = 0, checked = 0, txCount = 0, gapCount = 0;

  always #10 clk = ~clk;
  always @(negedge clk) bitTick <= ~bitTick;
  always @(negedge clk)
  begin
    if (txStart === 1'b1) txCount++;
    if (gapDue === 1'b1) gapCount++;
  end

  output_fault_substitution #(.MS_TICK_CYCLES_P(10), .SLOT_UNIT_P(5)) i_output_fault_substitution (
    .clk, .rst_n, .syncClear, .blockAccess, .timeoutMs, .blockData, .faultPattern, .slaveInData,
    .moduleGroup, .groupCmd, .busOutData, .hostInData, .faultActive, .busCfg, .bitTick, .reqTrigger,
    .respValid, .txStart, .respOk, .respEarly, .respLate, .noAnswer, .retryCount, .busBusy, .tokenRx,
    .rotationOverrun, .gapDue, .gapAddr, .prmStage, .prmWatchdogMs, .cfgError);
  slave_model i_slave_model (.clk, .rst_n, .bitTick, .txStart, .replyDly, .respValid);

  ////////////////////////////////////////
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errCount++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out;
    if (errCount == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic access0;
    blockAccess[0] = 1'b1;
    tick(1);
    blockAccess[0] = 1'b0;
  endtask : access0
  task automatic txn(input logic [7:0] d, input logic e, input logic l, input logic none);
    int k;
    replyDly = d;
    txCount = 0;
    reqTrigger = 1'b1;
    tick(1);
    reqTrigger = 1'b0;
    tick(2);
    reqTrigger = 1'b1;
    tick(1);
    reqTrigger = 1'b0;
    for (k = 0; k < 3000 && respOk !== 1'b1 && noAnswer !== 1'b1; k++) tick(1);
    chk(respOk, !none);
    chk(respEarly, e);
    chk(respLate, l);
    chk(noAnswer, none);
    chk(k >= 1000, none);
    chk(txCount, none ? 2 : 1);
    chk(retryCount, none ? 4'h1 : 4'h0);
    tick(2);
  endtask : txn

  ////////////////////////////////////////
  initial
  begin
    repeat (40000) @(posedge clk);
    errCount++;
    close_out();
  end

  initial
  begin
    tick(5);
    rst_n = 1'b1;
    tick(1);
    chk(faultActive, 4'h0);
    chk(busOutData[0], 64'h0);
    foreach (rows[i])
    begin
      timeoutMs[0] = rows[i].tmo;
      access0();
      tick(950);
      chk(faultActive[0], 1'b0);
      tick(80);
      chk(faultActive[0], rows[i].flt);
      chk(faultActive[1], 1'b0);
      chk(busOutData[0], rows[i].flt ? faultPattern[0] : blockData[0]);
    end
    timeoutMs[0] = 16'h0064;
    access0();
    tick(900);
    access0();
    tick(900);
    chk(faultActive[0], 1'b0);
    tick(200);
    chk(faultActive[0], 1'b1);
    syncClear = 1'b1;
    tick(1);
    syncClear = 1'b0;
    chk(faultActive[0], 1'b0);
    tick(1100);
    chk(faultActive[0], 1'b1);
    access0();
    tick(2);
    chk(faultActive[0], 1'b0);
    chk(busOutData[0], blockData[0]);
    groupCmd[1].sync = 1'b1;
    groupCmd[1].freeze = 1'b1;
    tick(1);
    groupCmd[1] = '0;
    blockData[2] = 64'h5555aaaa5555aaaa;
    slaveInData[2] = 64'h2222;
    tick(3);
    chk(busOutData[2], 64'h0123456789abcdef);
    chk(hostInData[2], 64'h1111);
    groupCmd[1].unsync = 1'b1;
    groupCmd[1].unfreeze = 1'b1;
    tick(1);
    groupCmd[1] = '0;
    tick(3);
    chk(busOutData[2], 64'h5555aaaa5555aaaa);
    chk(hostInData[2], 64'h2222);
    txn(8'h0f, 1'b0, 1'b0, 1'b0);
    txn(8'h05, 1'b1, 1'b0, 1'b0);
    txn(8'h1e, 1'b0, 1'b1, 1'b0);
    txn(8'h00, 1'b0, 1'b0, 1'b1);
    chk(cfgError, 1'b0);
    busCfg.minTsdr = 8'h0a;
    tick(1);
    chk(cfgError, 1'b1);
    busCfg.minTsdr = 8'h0b;
    prmStage = 1'b1;
    tick(1);
    prmStage = 1'b0;
    tick(1);
    chk(prmWatchdogMs, 16'h00fa);
    repeat (6)
    begin
      tokenRx = 1'b1;
      tick(1);
      tokenRx = 1'b0;
      tick(2);
    end
    chk(gapCount, 3);
    chk(gapAddr, 7'h03);
    chk(rotationOverrun, 1'b0);
    tick(2200);
    tokenRx = 1'b1;
    tick(1);
    chk(rotationOverrun, 1'b1);
    tick(1);
    tokenRx = 1'b0;
    tick(1);
    chk(gapAddr, 7'h00);
    chk(gapCount, 4);
    close_out();
  end
endmodule : testbench
